// file: src/tpc_dev.sv
// How it works
// - Busy stays high while access is serviced
// - Busy clears on a high-speed clock tick
// - Host polls busy low before next access
// - Each access finishes within 640 ns
// - Address/control write starts one access cycle
// - Top bit one reads, zero writes
// - Data buffer supplies writes, receives reads
// - Host loads data before write address
// - Read data lands in buffer within 640 ns
// - Tables at 20H, 40H, 60H, 32 each
// - Entry index equals timeslot or channel number
// - Conditioning byte field order from bit 7
// - T1 full inversion inverts whole channel
// - T1 idle bit substitutes stored idle code
// - Fractional mode gates backplane clock per channel
// - T1 sign inversion flips only the MSB
// - Both inversions give magnitude inversion
// - T1 milliwatt bit substitutes milliwatt pattern
// - Priority loopback, milliwatt, test, idle, inversion
// - Per-channel bytes used only when enabled
// - Software sets indirect enable after reset
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tpc_dev
	import tpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	tpc_bus_if.dev bus,
	input wire logic bit_tick_i,
	input wire logic [4:0] channel_i,
	input wire logic [2:0] bit_idx_i,
	input wire logic t1_mode_i,
	input wire logic fractional_channel_mode_i,
	input wire logic test_overwrite_i,
	input wire logic backplane_tx_pcm_in_i,
	input wire logic loop_bit_i,
	input wire logic test_bit_i,
	output logic pcm_out_o,
	output logic backplane_tx_clock_o,
	output logic per_channel_enable_o,
	output logic [1:0] zero_suppress_sel_o,
	output logic test_select_o,
	output logic [7:0] sig_ctrl_o
);
	logic [7:0] cfg;
	logic [7:0] addr_ctrl;
	logic [7:0] data_buf;
	logic [7:0] rdata;
	logic busy;
	logic [1:0] hs_cnt;
	logic hs_tick;
	logic [3:0] svc_cnt;
	logic start;
	logic done;
	logic [7:0] pcm_tab [TPC_CHANNELS];
	logic [7:0] idle_tab [TPC_CHANNELS];
	logic [7:0] sig_tab [TPC_CHANNELS];
	logic [7:0] cur_pcm;
	logic [7:0] cur_idle;
	logic per_channel_enable;
	logic ind_en;
	logic msb_slot;
	logic inv_bit;
	logic next_pcm;
	logic next_clk;

	// Fetch one table byte; group from bits 6:5, entry from bits 4:0
	function automatic logic [7:0] tab_read(input logic [6:0] a, input logic [7:0] p,
			input logic [7:0] i, input logic [7:0] s);
		logic [7:0] r;
		r = 8'h00;
		case (a[6:5])
			TPC_GRP_PCM: r = p;
			TPC_GRP_IDLE: r = i;
			TPC_GRP_SIG: r = s;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// Host bus write decode
	function automatic logic bus_hit(input logic wr, input logic [7:0] a,
			input logic [7:0] off);
		return wr && (a == off);
	endfunction

	assign per_channel_enable = cfg[TPC_CFG_PER_CHANNEL_ENABLE_BIT];
	assign ind_en = cfg[TPC_CFG_IND_BIT];

	// Start only with indirect mode on, a table address and no access in flight
	assign start = bus_hit(bus.wr, bus.addr, TPC_REG_ADDR_CTRL) && !busy && ind_en
		&& (bus.wdata[6:5] != 2'h0);
	assign done = busy && hs_tick && (svc_cnt == 4'(TPC_SERVICE_TICKS - 1));

	// Internal high-speed clock as an enable from a divider
	assign hs_tick = (hs_cnt == 2'(TPC_HS_DIV - 1));
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hs_cnt <= 2'h0;
		end else if (hs_tick) begin
			hs_cnt <= 2'h0;
		end else begin
			hs_cnt <= hs_cnt + 2'h1;
		end
	end

	// Busy rises at the accepting edge and falls on a tick when serviced
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy <= 1'b0;
			svc_cnt <= 4'h0;
		end else if (start) begin
			busy <= 1'b1;
			svc_cnt <= 4'h0;
		end else if (done) begin
			busy <= 1'b0;
			svc_cnt <= 4'h0;
		end else if (busy && hs_tick) begin
			svc_cnt <= svc_cnt + 4'h1;
		end
	end

	// Configuration; reserved upper bits read zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cfg <= TPC_CFG_RST;
		end else if (bus_hit(bus.wr, bus.addr, TPC_REG_CFG)) begin
			cfg <= bus.wdata & TPC_CFG_MASK;
		end
	end

	// Address is frozen while busy so a stray write cannot retarget it
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			addr_ctrl <= TPC_ADDR_CTRL_RST;
		end else if (bus_hit(bus.wr, bus.addr, TPC_REG_ADDR_CTRL) && !busy) begin
			addr_ctrl <= bus.wdata;
		end
	end

	// Completed read wins over a host write to the buffer
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			data_buf <= TPC_DATA_RST;
		end else if (done && addr_ctrl[TPC_RNW_BIT]) begin
			data_buf <= tab_read(addr_ctrl[6:0], pcm_tab[addr_ctrl[4:0]],
				idle_tab[addr_ctrl[4:0]], sig_tab[addr_ctrl[4:0]]);
		end else if (bus_hit(bus.wr, bus.addr, TPC_REG_DATA)) begin
			data_buf <= bus.wdata;
		end
	end

	// Tables have no reset; contents stay undefined until written
	always_ff @(posedge clk_i) begin
		if (done && !addr_ctrl[TPC_RNW_BIT]) begin
			case (addr_ctrl[6:5])
				TPC_GRP_PCM: pcm_tab[addr_ctrl[4:0]] <= data_buf;
				TPC_GRP_IDLE: idle_tab[addr_ctrl[4:0]] <= data_buf;
				TPC_GRP_SIG: sig_tab[addr_ctrl[4:0]] <= data_buf;
				default: ;
			endcase
		end
	end

	// Register read port, answer one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				TPC_REG_CFG: rdata <= cfg;
				TPC_REG_STATUS: rdata <= {busy, 7'h00};
				TPC_REG_ADDR_CTRL: rdata <= addr_ctrl;
				TPC_REG_DATA: rdata <= data_buf;
				default: rdata <= 8'h00;
			endcase
		end
	end
	assign bus.rdata = rdata;

	// Current channel's bytes
	assign cur_pcm = pcm_tab[channel_i];
	assign cur_idle = idle_tab[channel_i];
	assign msb_slot = (bit_idx_i == 3'h0);

	// MSB flips on exactly one inversion bit, the others follow full inversion
	assign inv_bit = msb_slot ? (cur_pcm[TPC_PCM_INVERT] ^ cur_pcm[TPC_PCM_SIGN])
		: cur_pcm[TPC_PCM_INVERT];

	// Bit selection by priority; T1-only functions drop out in E1
	always_comb begin
		next_pcm = backplane_tx_pcm_in_i;
		if (!per_channel_enable) begin
			next_pcm = backplane_tx_pcm_in_i;
		end else if (cur_pcm[TPC_PCM_LOOP]) begin
			next_pcm = loop_bit_i;
		end else if (t1_mode_i && cur_pcm[TPC_PCM_MW]) begin
			next_pcm = TPC_MILLIWATT_BYTE[~bit_idx_i];
		end else if (cur_pcm[TPC_PCM_TEST] && test_overwrite_i) begin
			next_pcm = test_bit_i;
		end else if (t1_mode_i && cur_pcm[TPC_PCM_IDLE]) begin
			next_pcm = cur_idle[~bit_idx_i];
		end else if (t1_mode_i) begin
			next_pcm = backplane_tx_pcm_in_i ^ inv_bit;
		end
	end

	// Clock gating ignores the priority order: idle bit alone decides
	assign next_clk = bit_tick_i && !(fractional_channel_mode_i && per_channel_enable
		&& cur_pcm[TPC_PCM_IDLE]);

	// Output bit and clock pulse, one cycle after the bit tick
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pcm_out_o <= 1'b0;
			backplane_tx_clock_o <= 1'b0;
		end else begin
			backplane_tx_clock_o <= next_clk;
			if (bit_tick_i) begin
				pcm_out_o <= next_pcm;
			end
		end
	end

	// Bytes handed on to the transmitter only while enabled
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			per_channel_enable_o <= 1'b0;
			zero_suppress_sel_o <= 2'h0;
			test_select_o <= 1'b0;
			sig_ctrl_o <= 8'h00;
		end else if (per_channel_enable) begin
			per_channel_enable_o <= 1'b1;
			zero_suppress_sel_o <= {cur_pcm[TPC_PCM_ZS_HI], cur_pcm[TPC_PCM_ZS_LO]};
			test_select_o <= cur_pcm[TPC_PCM_TEST];
			sig_ctrl_o <= sig_tab[channel_i];
		end else begin
			per_channel_enable_o <= 1'b0;
			zero_suppress_sel_o <= 2'h0;
			test_select_o <= 1'b0;
			sig_ctrl_o <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// file: src/tpc_pkg.sv
// Shared constants for the indirect table port and its host sequencer
package tpc_pkg;
	// Device register offsets on the device bus
	localparam logic [7:0] TPC_REG_CFG = 8'h6c;
	localparam logic [7:0] TPC_REG_STATUS = 8'h6d;
	localparam logic [7:0] TPC_REG_ADDR_CTRL = 8'h6e;
	localparam logic [7:0] TPC_REG_DATA = 8'h6f;

	// Reset values
	localparam logic [7:0] TPC_CFG_RST = 8'h00;
	localparam logic [7:0] TPC_ADDR_CTRL_RST = 8'h00;
	localparam logic [7:0] TPC_DATA_RST = 8'h00;

	// Field positions
	localparam int TPC_BUSY_BIT = 7;
	localparam int TPC_RNW_BIT = 7;
	localparam int TPC_CFG_PER_CHANNEL_ENABLE_BIT = 0;
	localparam int TPC_CFG_IND_BIT = 1;
	localparam logic [7:0] TPC_CFG_MASK = 8'h07;

	// Per-channel conditioning byte layout
	localparam int TPC_PCM_INVERT = 7;
	localparam int TPC_PCM_IDLE = 6;
	localparam int TPC_PCM_MW = 5;
	localparam int TPC_PCM_SIGN = 4;
	localparam int TPC_PCM_TEST = 3;
	localparam int TPC_PCM_LOOP = 2;
	localparam int TPC_PCM_ZS_HI = 1;
	localparam int TPC_PCM_ZS_LO = 0;

	// Table groups, selected by internal address bits 6:5
	localparam logic [1:0] TPC_GRP_PCM = 2'h1;
	localparam logic [1:0] TPC_GRP_IDLE = 2'h2;
	localparam logic [1:0] TPC_GRP_SIG = 2'h3;
	localparam int TPC_CHANNELS = 32;

	// Access timing
	localparam int TPC_CLK_NS = 10;
	localparam int TPC_ACCESS_NS = 640;
	localparam int TPC_ACCESS_CYC = TPC_ACCESS_NS / TPC_CLK_NS;
	localparam int TPC_HS_DIV = 4;
	localparam int TPC_SERVICE_TICKS = TPC_ACCESS_CYC / TPC_HS_DIV - 1;

	// Milliwatt byte sent MSB first; plain default value
	localparam logic [7:0] TPC_MILLIWATT_BYTE = 8'h1e;

	// Host-side Avalon offsets (byte addresses)
	localparam logic [3:0] TPC_HOST_CMD = 4'h0;
	localparam logic [3:0] TPC_HOST_CFG = 4'h4;
	localparam logic [3:0] TPC_HOST_STAT = 4'h8;
	localparam int TPC_CMD_ADDR_LSB = 8;
	localparam int TPC_CMD_RNW_BIT = 15;
	localparam int TPC_STAT_DATA_LSB = 8;
endpackage

// file: src/tpc_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Byte-wide register bus between the host sequencer and the device
interface tpc_bus_if;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dev(input addr, input wr, input rd, input wdata, output rdata);
	modport host(output addr, output wr, output rd, output wdata, input rdata);
endinterface
`default_nettype wire

// file: src/tpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_host
	import tpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	tpc_bus_if.host bus
);
	typedef enum {
		TPC_S_IDLE, TPC_S_CFG_WR, TPC_S_PRE_RD, TPC_S_PRE_CHK, TPC_S_DATA_WR,
		TPC_S_ADDR_WR, TPC_S_POST_RD, TPC_S_POST_CHK, TPC_S_FETCH_RD, TPC_S_FETCH_CHK
	} tpc_state_t;

	tpc_state_t state;
	logic [6:0] cmd_addr;
	logic cmd_rnw;
	logic [7:0] cmd_data;
	logic [7:0] cfg_val;
	logic [7:0] result;
	logic rd_ack;
	logic take_wr;
	logic dev_busy;

	assign take_wr = avs_write_i && (state == TPC_S_IDLE);
	assign avs_waitrequest_o = (avs_read_i && !rd_ack) || (avs_write_i && !take_wr);
	assign dev_busy = bus.rdata[TPC_BUSY_BIT];

	// Reads stall one cycle so read data comes from a flop
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_ack <= 1'b0;
			avs_readdata_o <= 32'h0;
		end else begin
			rd_ack <= avs_read_i && !rd_ack;
			if (avs_read_i && !rd_ack) begin
				case (avs_address_i)
					TPC_HOST_CMD: avs_readdata_o <= {16'h0, cmd_rnw, cmd_addr, cmd_data};
					TPC_HOST_CFG: avs_readdata_o <= {24'h0, cfg_val};
					TPC_HOST_STAT: avs_readdata_o <= {16'h0, result, 7'h0, state != TPC_S_IDLE};
					default: avs_readdata_o <= 32'h0;
				endcase
			end
		end
	end

	// Command capture
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cmd_addr <= 7'h00;
			cmd_rnw <= 1'b0;
			cmd_data <= 8'h00;
			cfg_val <= 8'h00;
		end else if (take_wr && avs_address_i == TPC_HOST_CMD) begin
			cmd_data <= avs_writedata_i[7:0];
			cmd_addr <= avs_writedata_i[TPC_CMD_ADDR_LSB +: 7];
			cmd_rnw <= avs_writedata_i[TPC_CMD_RNW_BIT];
		end else if (take_wr && avs_address_i == TPC_HOST_CFG) begin
			cfg_val <= avs_writedata_i[7:0];
		end
	end

	// Access sequencer: poll idle, data before address, poll done, fetch
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= TPC_S_IDLE;
			result <= 8'h00;
		end else begin
			case (state)
				TPC_S_IDLE: begin
					if (take_wr && avs_address_i == TPC_HOST_CMD) begin
						state <= TPC_S_PRE_RD;
					end else if (take_wr && avs_address_i == TPC_HOST_CFG) begin
						state <= TPC_S_CFG_WR;
					end
				end
				TPC_S_CFG_WR: state <= TPC_S_IDLE;
				TPC_S_PRE_RD: state <= TPC_S_PRE_CHK;
				TPC_S_PRE_CHK: begin
					if (dev_busy) begin
						state <= TPC_S_PRE_RD;
					end else if (cmd_rnw) begin
						state <= TPC_S_ADDR_WR;
					end else begin
						state <= TPC_S_DATA_WR;
					end
				end
				TPC_S_DATA_WR: state <= TPC_S_ADDR_WR;
				TPC_S_ADDR_WR: state <= TPC_S_POST_RD;
				TPC_S_POST_RD: state <= TPC_S_POST_CHK;
				TPC_S_POST_CHK: begin
					if (dev_busy) begin
						state <= TPC_S_POST_RD;
					end else if (cmd_rnw) begin
						state <= TPC_S_FETCH_RD;
					end else begin
						state <= TPC_S_IDLE;
					end
				end
				TPC_S_FETCH_RD: state <= TPC_S_FETCH_CHK;
				TPC_S_FETCH_CHK: begin
					result <= bus.rdata;
					state <= TPC_S_IDLE;
				end
				default: state <= TPC_S_IDLE;
			endcase
		end
	end

	// Bus drive decoded from the state; one strobe per state visit
	always_comb begin
		bus.wr = 1'b0;
		bus.rd = 1'b0;
		bus.addr = TPC_REG_STATUS;
		bus.wdata = 8'h00;
		case (state)
			TPC_S_CFG_WR: begin
				bus.wr = 1'b1;
				bus.addr = TPC_REG_CFG;
				bus.wdata = cfg_val;
			end
			TPC_S_PRE_RD, TPC_S_POST_RD: bus.rd = 1'b1;
			TPC_S_DATA_WR: begin
				bus.wr = 1'b1;
				bus.addr = TPC_REG_DATA;
				bus.wdata = cmd_data;
			end
			TPC_S_ADDR_WR: begin
				bus.wr = 1'b1;
				bus.addr = TPC_REG_ADDR_CTRL;
				bus.wdata = {cmd_rnw, cmd_addr};
			end
			TPC_S_FETCH_RD: begin
				bus.rd = 1'b1;
				bus.addr = TPC_REG_DATA;
			end
			default: ;
		endcase
	end
endmodule
`default_nettype wire

// file: tb/tpc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_checker
	import tpc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	logic ind_en;
	logic act;
	logic act_rd;
	logic [5:0] cnt;
	logic [6:0] act_addr;
	logic [7:0] buf_sh;
	logic [7:0] tbl [128];
	logic start_ok;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// An accepted start needs the enable, a table address and an idle port
	assign start_ok = wr && addr == TPC_REG_ADDR_CTRL && ind_en && wdata[6:5] != 2'h0 && !act;

	// Shadow of the indirect enable bit
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			ind_en <= 1'b0;
		else if (wr && addr == TPC_REG_CFG)
			ind_en <= wdata[TPC_CFG_IND_BIT];
	end

	// Service window; kept to 60 cycles so a late clear still counts as busy
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			act <= 1'b0;
			cnt <= 6'h0;
			act_rd <= 1'b0;
			act_addr <= 7'h0;
		end else if (start_ok) begin
			act <= 1'b1;
			cnt <= 6'h0;
			act_rd <= wdata[TPC_RNW_BIT];
			act_addr <= wdata[6:0];
		end else if (act) begin
			cnt <= cnt + 6'h1;
			if (cnt == 6'd59)
				act <= 1'b0;
		end
	end

	// Buffer shadow; a completed read replaces the host's byte
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			buf_sh <= 8'h00;
		else if (act && act_rd && cnt == 6'd59)
			buf_sh <= tbl[act_addr];
		else if (wr && addr == TPC_REG_DATA)
			buf_sh <= wdata;
	end

	// Table shadow, not reset like the real tables
	always_ff @(posedge clk_i) begin
		if (start_ok && !wdata[TPC_RNW_BIT])
			tbl[wdata[6:0]] <= buf_sh;
	end

	property p_busy_held;
		rd && addr == TPC_REG_STATUS && act && cnt <= 6'd55 |=> rdata[TPC_BUSY_BIT];
	endproperty
	a_busy_held: assert property (p_busy_held)
		else $error("busy low while access in service");
	property p_busy_done;
		rd && addr == TPC_REG_STATUS && !act |=> rdata == 8'h00;
	endproperty
	a_busy_done: assert property (p_busy_done)
		else $error("busy still high after service time");
	property p_no_start_busy;
		act && cnt <= 6'd55 |-> !(wr && addr == TPC_REG_ADDR_CTRL);
	endproperty
	a_no_start_busy: assert property (p_no_start_busy)
		else $error("new access started while busy");
	property p_write_order;
		wr && addr == TPC_REG_ADDR_CTRL && !wdata[TPC_RNW_BIT] |-> $past(wr) && $past(addr) == TPC_REG_DATA;
	endproperty
	a_write_order: assert property (p_write_order)
		else $error("write access not preceded by data load");
	property p_read_addr_only;
		wr && addr == TPC_REG_ADDR_CTRL && wdata[TPC_RNW_BIT] |-> !($past(wr) && $past(addr) == TPC_REG_DATA);
	endproperty
	a_read_addr_only: assert property (p_read_addr_only)
		else $error("read access preceded by data load");
	property p_buf_data;
		rd && addr == TPC_REG_DATA && !act |=> rdata == buf_sh;
	endproperty
	a_buf_data: assert property (p_buf_data)
		else $error("data buffer holds wrong byte");
	property p_poll_soon;
		start_ok |=> (rd && addr == TPC_REG_STATUS) ##1 rdata[TPC_BUSY_BIT];
	endproperty
	a_poll_soon: assert property (p_poll_soon)
		else $error("busy not set right after start");
	property p_rdata_hold;
		!rd |=> $stable(rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without a read");
	property p_excl;
		!(rd && wr);
	endproperty
	a_excl: assert property (p_excl)
		else $error("read and write together");
endmodule
`default_nettype wire

// file: tb/test_tx_per_channel_indirect_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_tx_per_channel_indirect_control
	import tpc_pkg::*;
();
	localparam logic [7:0] DIN = 8'hb4;
	localparam logic [7:0] IDLE_B = 8'hc3;
	localparam logic [6:0] TA [8] = '{7'h20, 7'h3f, 7'h41, 7'h58, 7'h40, 7'h5f, 7'h60, 7'h7f};
	// {enable, fractional, t1, control byte}
	localparam logic [10:0] CS [18] = '{11'h501, 11'h580, 11'h510, 11'h592, 11'h540, 11'h520,
		11'h508, 11'h504, 11'h564, 11'h560, 11'h548, 11'h588, 11'h480, 11'h440, 11'h408,
		11'h740, 11'h703, 11'h180};
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic bit_tick_i = 1'b0;
	logic [4:0] channel_i = 5'h0;
	logic [2:0] bit_idx_i = 3'h0;
	logic t1_mode_i = 1'b0;
	logic fractional_channel_mode_i = 1'b0;
	logic backplane_tx_pcm_in_i = 1'b0;
	logic loop_bit_i = 1'b0;
	logic test_bit_i = 1'b0;
	logic pcm_out_o;
	logic backplane_tx_clock_o;
	logic per_channel_enable_o;
	logic [1:0] zero_suppress_sel_o;
	logic test_select_o;
	logic [7:0] sig_ctrl_o;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;

	tpc_bus_if bus_if();
	tpc_host tpc_host_i(.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .bus(bus_if));
	tpc_dev tpc_dev_i(.clk_i, .rst_n_i, .bus(bus_if), .bit_tick_i, .channel_i, .bit_idx_i,
		.t1_mode_i, .fractional_channel_mode_i, .test_overwrite_i(1'b1), .backplane_tx_pcm_in_i,
		.loop_bit_i, .test_bit_i, .pcm_out_o, .backplane_tx_clock_o, .per_channel_enable_o,
		.zero_suppress_sel_o, .test_select_o, .sig_ctrl_o);
	tpc_checker tpc_checker_i(.clk_i, .rst_n_i, .addr(bus_if.addr), .wr(bus_if.wr),
		.rd(bus_if.rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata));

	// Free-running 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One Avalon transfer; waitrequest looked at before the edge, so no race
	task automatic av(input logic rnw, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		logic w;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_read_i <= rnw;
		avs_write_i <= !rnw;
		avs_writedata_i <= d;
		do begin
			@(negedge clk_i);
			w = avs_waitrequest_o;
			q = avs_readdata_o;
			@(posedge clk_i);
			n++;
		end while (w !== 1'b0 && n < 500);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n >= 500)
			n_mismatch++;
	endtask

	// Indirect access, then status polled until the sequencer is idle
	task automatic indirect_access_enable(input logic rnw, input logic [6:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		av(1'b0, TPC_HOST_CMD, {16'h0, rnw, a, d}, q);
		do begin
			av(1'b1, TPC_HOST_STAT, 32'h0, q);
			n++;
		end while (q[0] !== 1'b0 && n < 300);
		if (n >= 300)
			n_mismatch++;
	endtask

	function automatic logic exp_bit(input logic [10:0] c, input int i);
		logic d;
		d = DIN[7 - i];
		if (!c[10])
			return d;
		if (c[TPC_PCM_LOOP])
			return i[0];
		if (c[8] && c[TPC_PCM_MW])
			return TPC_MILLIWATT_BYTE[7 - i];
		if (c[TPC_PCM_TEST])
			return i[1];
		if (c[8] && c[TPC_PCM_IDLE])
			return IDLE_B[7 - i];
		if (!c[8])
			return d;
		return d ^ c[TPC_PCM_INVERT] ^ (i == 0 && c[TPC_PCM_SIGN]);
	endfunction

	// One channel byte, MSB first, ticks three cycles apart
	task automatic send_byte(input logic [10:0] c, input logic [4:0] ch);
		int np;
		logic en;
		np = 0;
		en = c[10];
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			t1_mode_i <= c[8];
			fractional_channel_mode_i <= c[9];
			channel_i <= ch;
			bit_idx_i <= 3'(i);
			backplane_tx_pcm_in_i <= DIN[7 - i];
			loop_bit_i <= i[0];
			test_bit_i <= i[1];
			bit_tick_i <= 1'b1;
			@(posedge clk_i);
			bit_tick_i <= 1'b0;
			@(negedge clk_i);
			check("pcm", 32'(exp_bit(c, i)), 32'(pcm_out_o));
			np += int'(backplane_tx_clock_o);
			@(posedge clk_i);
			@(negedge clk_i);
			np += int'(backplane_tx_clock_o);
		end
		check("bclk", (c[9] && en && c[TPC_PCM_IDLE]) ? 32'd0 : 32'd8, 32'(np));
		check("chan", {en, en ? {c[3], c[1:0], 3'h5, ch} : 11'h0}, {per_channel_enable_o,
			test_select_o, zero_suppress_sel_o, sig_ctrl_o});
	endtask

	// Main sequence
	initial begin
		logic [31:0] q;
		logic [10:0] c;
		logic [4:0] ch;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		av(1'b1, TPC_HOST_STAT, 32'h0, q);
		check("stat", 32'h0, q);
		indirect_access_enable(1'b0, 7'h21, 8'h99, q);
		indirect_access_enable(1'b1, 7'h21, 8'h00, q);
		check("noind", 32'h99, 32'(q[15:8]));
		$display("test reset and disabled access done");
		av(1'b0, TPC_HOST_CFG, 32'h2, q);
		for (int k = 0; k < 8; k++)
			indirect_access_enable(1'b0, TA[k], {1'b0, TA[k]} ^ 8'h96, q);
		for (int k = 0; k < 8; k++) begin
			indirect_access_enable(1'b1, TA[k], 8'h00, q);
			check("tbl", 32'({1'b0, TA[k]} ^ 8'h96), 32'(q[15:8]));
		end
		$display("test table access done");
		for (int k = 0; k < 18; k++) begin
			c = CS[k];
			ch = 5'(k + 3);
			av(1'b0, TPC_HOST_CFG, {30'h0, 1'b1, c[10]}, q);
			indirect_access_enable(1'b0, {2'h1, ch}, c[7:0], q);
			indirect_access_enable(1'b0, {2'h2, ch}, IDLE_B, q);
			indirect_access_enable(1'b0, {2'h3, ch}, {3'h5, ch}, q);
			send_byte(c, ch);
		end
		$display("test channel conditioning done");
		final_report();
	end
endmodule
`default_nettype wire
